// ==== hdl/rail_seq_pkg.sv ====
// constants and types shared by the four-rail sequencer
// assumes a 125 MHz control clock; timer counts are derived from it
package rail_seq_pkg;
   localparam int unsigned CLOCK_HZ = 125000000;
   localparam int unsigned RAIL_COUNT = 4;
   // times in their printed units
   localparam int unsigned WAKE_US = 420;
   localparam int unsigned GAP_US = 500;
   localparam int unsigned HOLD_MS = 50;
   localparam int unsigned TRIP_DELAY_MS = 5;
   localparam int unsigned SAFETY_S = 2;
   // derived cycle counts
   localparam int unsigned WAKE_CYC = WAKE_US * (CLOCK_HZ / 1000000);
   localparam int unsigned GAP_CYC = GAP_US * (CLOCK_HZ / 1000000);
   localparam int unsigned HOLD_CYC = HOLD_MS * (CLOCK_HZ / 1000);
   localparam int unsigned TRIP_DELAY_CYC = TRIP_DELAY_MS * (CLOCK_HZ / 1000);
   localparam int unsigned SAFETY_CYC = SAFETY_S * CLOCK_HZ;
   localparam int TIMER_WIDTH = 32;
   // rail 3 target codes on the select output
   localparam logic RAIL3_LOW_SETTING = 1'h0;
   localparam logic RAIL3_HIGH_SETTING = 1'h1;

   // one-hot sequencer states
   typedef enum logic [5:0] {
      ST_SHUTDOWN = 6'h01, // references off, all rails off
      ST_WAKE = 6'h02,     // references settling
      ST_ACTIVE = 6'h04,   // rails follow their enables
      ST_TRIP_WAIT = 6'h08, // fault seen, good low, converters still on
      ST_FAULT_OFF = 6'h10, // converters off, waiting for fault to end
      ST_RESTART = 6'h20   // ordered start 1,2,3,4
   } seq_state_type;
endpackage : rail_seq_pkg

// ==== hdl/quad_rail_sequencer_supervisor.sv ====
// four-rail step-down supervisor: wake-up, per-rail control, power-good, faults
// assumes analog comparators and pins arrive asynchronous; long timers are
// parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - first enable waits wake delay before start
// - enable while active starts rail immediately
// - good released when rail reaches rising threshold
// - good drops below falling, returns above rising
// - good low stays low for hold time
// - enable low drops good, stops converter
// - discharge pulldown only while enable low
// - all enables low enters shutdown, references off
// - rail three target follows voltage select
// - overheat drops good, stops after delay
// - overheat clear waits safety interval before restart
// - restart order 1,2,3,4 with fixed gap
// - input low stops all now, restarts on clear
// - input low release after hold and settle
// - input high drops good, stops if persisting
// - short input high keeps converters, holds good
// - input high release after hold and settle
// - good outputs pull low only, else float
// - wake delay runs from enable to switching
module quad_rail_sequencer_supervisor
   import rail_seq_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = WAKE_CYC,
   parameter int unsigned GAP_CYCLES = GAP_CYC,
   parameter int unsigned HOLD_CYCLES = HOLD_CYC,
   parameter int unsigned TRIP_CYCLES = TRIP_DELAY_CYC,
   parameter int unsigned SAFETY_CYCLES = SAFETY_CYC
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] rail_enable_in,       // host enables, asynchronous
   input wire logic rail3_voltage_select,        // rail 3 setting pin
   input wire logic [3:0] rail_feedback_node,    // in-regulation comparators
   input wire logic overheat_trip,               // thermal comparator
   input wire logic input_low_lockout,           // input undervoltage
   input wire logic input_high_trip,             // input overvoltage
   output logic [3:0] rail_good_out,             // open-drain output value (always 0)
   output logic [3:0] rail_good_oe,              // low = pulling pin low
   output logic [3:0] converter_run,             // per-rail converter on
   output logic [3:0] discharge_on,              // per-rail output pulldown
   output logic reference_on,                    // internal references powered
   output logic rail3_target_high                // rail 3 target setting
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks
   if (WAKE_CYCLES < 1 || GAP_CYCLES < 1 || HOLD_CYCLES < 1 ||
       TRIP_CYCLES < 1 || SAFETY_CYCLES < 1 ||
       64'(SAFETY_CYCLES) >= (64'h1 << TIMER_WIDTH))
   begin : g_bad_param
      $error("timer parameters must be at least one cycle and fit the timer");
   end

   ////////////////////////////////////////////////////////////////////////
   // state record
   typedef struct packed {
      logic [3:0] en_s1;            // first synchroniser stage
      logic [3:0] en_s2;            // synchronised enables
      logic [3:0] fb_s1;
      logic [3:0] fb_s2;
      logic [2:0] flt_s1;           // overheat, input low, input high
      logic [2:0] flt_s2;
      logic sel_s1;
      logic sel_s2;
      seq_state_type state;
      logic [TIMER_WIDTH-1:0] timer; // shared sequencing timer
      logic [1:0] next_rail;          // restart pointer
      logic [3:0] run;                // converter enables
      logic [3:0] good;               // released power-good
      logic [3:0][TIMER_WIDTH-1:0] hold; // per-rail hold-off counters
      logic sel;
      logic ref_on;
      logic tripped_overheat;         // overheat caused this fault
   } core_type;

   core_type q;
   core_type d;

   logic [3:0] en;
   logic [3:0] fb;
   logic heat;
   logic lowin;
   logic highin;
   logic any_fault;

   // only second stages are read by logic
   assign en = q.en_s2;
   assign fb = q.fb_s2;
   assign heat = q.flt_s2[0];
   assign lowin = q.flt_s2[1];
   assign highin = q.flt_s2[2];
   assign any_fault = heat | lowin | highin;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      d = q;
      // two-stage synchronisers for every outside input
      d.en_s1 = rail_enable_in;
      d.en_s2 = q.en_s1;
      d.fb_s1 = rail_feedback_node;
      d.fb_s2 = q.fb_s1;
      d.flt_s1 = {input_high_trip, input_low_lockout, overheat_trip};
      d.flt_s2 = q.flt_s1;
      d.sel_s1 = rail3_voltage_select;
      d.sel_s2 = q.sel_s1;
      d.sel = q.sel_s2; // rail 3 target follows the select pin
      if (q.timer != '0)
      begin
         d.timer = q.timer - 1'b1; // delays all counted on this clock
      end

      // per-rail power-good qualification
      for (int i = 0; i < RAIL_COUNT; i++)
      begin
         if (q.hold[i] != '0)
         begin
            d.hold[i] = q.hold[i] - 1'b1;
         end
         if (!q.run[i] || !fb[i] || !en[i])
         begin
            // below falling threshold, off, disabled or not yet up: pull low
            d.good[i] = 1'b0;
         end
         else if (q.hold[i] == '0)
         begin
            // settled output released once hold has expired
            d.good[i] = 1'b1;
         end
      end

      case (q.state)
         ST_SHUTDOWN:
         begin
            d.run = '0;
            d.ref_on = 1'b0; // references off while all enables low
            if (en != '0 && !lowin)
            begin
               d.ref_on = 1'b1;
               d.timer = TIMER_WIDTH'(WAKE_CYCLES); // wake delay from enable
               d.state = ST_WAKE;
            end
         end
         ST_WAKE:
         begin
            if (en == '0)
            begin
               d.state = ST_SHUTDOWN;
            end
            else if (any_fault)
            begin
               d.state = ST_FAULT_OFF;
               d.tripped_overheat = heat;
            end
            else if (q.timer == '0)
            begin
               d.run = en; // references settled, switching starts
               d.state = ST_ACTIVE;
            end
         end
         ST_ACTIVE:
         begin
            // rails follow enables directly, no wake delay
            d.run = en;
            if (lowin)
            begin
               d.run = '0; // input low stops everything at once
               d.good = '0;
               d.state = ST_FAULT_OFF;
               d.tripped_overheat = 1'b0;
            end
            else if (heat || highin)
            begin
               d.good = '0; // good drops at once, converters keep running
               d.timer = TIMER_WIDTH'(TRIP_CYCLES);
               d.state = ST_TRIP_WAIT;
            end
            else if (en == '0)
            begin
               d.state = ST_SHUTDOWN;
            end
         end
         ST_TRIP_WAIT:
         begin
            d.run = en;
            d.good = '0;
            if (lowin)
            begin
               d.run = '0;
               d.tripped_overheat = 1'b0;
               d.state = ST_FAULT_OFF;
            end
            else if (!heat && !highin)
            begin
               // brief input high: converters never stopped, hold still runs
               d.state = ST_ACTIVE;
            end
            else if (q.timer == '0)
            begin
               // persisted for the trip delay: shut everything down
               d.run = '0;
               d.tripped_overheat = heat;
               d.state = ST_FAULT_OFF;
            end
         end
         ST_FAULT_OFF:
         begin
            d.run = '0;
            if (any_fault)
            begin
               d.tripped_overheat = q.tripped_overheat | heat;
               // overheat restart waits the safety interval after clearing
               d.timer = (q.tripped_overheat | heat) ? TIMER_WIDTH'(SAFETY_CYCLES) : '0;
            end
            else if (en == '0)
            begin
               d.state = ST_SHUTDOWN;
            end
            else if (q.timer == '0)
            begin
               d.next_rail = 2'h0;
               d.state = ST_RESTART; // restart on clear
            end
         end
         ST_RESTART:
         begin
            if (any_fault)
            begin
               // abort the sequence and take the fault path
               d.run = '0;
               d.good = '0;
               d.tripped_overheat = heat;
               d.timer = '0;
               d.state = ST_FAULT_OFF;
            end
            else if (en == '0)
            begin
               d.state = ST_SHUTDOWN; // no rail wanted: references go off
            end
            else if (q.timer == '0)
            begin
               // rails 1..4 in order, gap between each start
               d.run[q.next_rail] = en[q.next_rail];
               d.timer = TIMER_WIDTH'(GAP_CYCLES);
               d.next_rail = q.next_rail + 2'h1;
               if (q.next_rail == 2'h3)
               begin
                  d.timer = '0;
                  d.state = ST_ACTIVE;
               end
            end
            d.run = d.run & en; // a dropped enable stops its rail at once
         end
         default:
         begin
            d.state = ST_SHUTDOWN;
            d.run = '0;
         end
      endcase
      if (d.state != ST_ACTIVE && d.state != ST_RESTART && d.state != ST_TRIP_WAIT)
      begin
         d.good = '0;
      end
      // any fall of a released good restarts its hold, whatever the cause;
      // fault paths clear good directly, so the hold cannot be armed earlier
      for (int i = 0; i < RAIL_COUNT; i++)
      begin
         if (q.good[i] && !d.good[i])
         begin
            d.hold[i] = TIMER_WIDTH'(HOLD_CYCLES);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         q <= '0;
         q.state <= ST_SHUTDOWN;
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign rail_good_out = '0;                // open-drain: only ever pulls low
   assign rail_good_oe = q.good;             // enable low = driving low
   assign converter_run = q.run;
   assign discharge_on = ~q.en_s2 | ~q.run & ~q.en_s2; // pulldown while enable low
   assign reference_on = q.ref_on;
   assign rail3_target_high = q.sel ? RAIL3_HIGH_SETTING : RAIL3_LOW_SETTING;

endmodule : quad_rail_sequencer_supervisor

`default_nettype wire

// ==== verification/rail_seq_monitor.sv ====
// port assertions for the four-rail sequencer
// bound to the top module; fault inputs are assumed quiet unless named
`timescale 1ns/1ps
`default_nettype none
module rail_seq_monitor #(
   parameter int unsigned WAKE_CYCLES = 20,
   parameter int unsigned HOLD_CYCLES = 200,
   parameter int unsigned TRIP_CYCLES = 50
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] rail_enable_in,
   input wire logic rail3_voltage_select,
   input wire logic overheat_trip,
   input wire logic [3:0] rail_good_out,
   input wire logic [3:0] rail_good_oe,
   input wire logic [3:0] converter_run,
   input wire logic [3:0] discharge_on,
   input wire logic reference_on,
   input wire logic rail3_target_high
);
   localparam int WK = WAKE_CYCLES - 1;
   localparam int TR_LO = TRIP_CYCLES - 8;
   localparam int TR_HI = TRIP_CYCLES + 4;
   localparam int HL = HOLD_CYCLES - 2;
   logic [31:0] low_q; // cycles rail 0 good has been low, saturating
   logic [31:0] low_d;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////
   // reset loads the saturated value: the first release has no hold
   always_comb
   begin
      low_d = rail_good_oe[0] ? 32'h00000000 : low_q + {31'h00000000, ~&low_q};
   end
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         low_q <= 32'hFFFFFFFF;
      else
         low_q <= low_d;
   end
   ////////////////////////////////////////////////////////////////
   property p_open_drain; rail_good_out == 4'h0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("good data driven high");
   property p_discharge; $stable(rail_enable_in) [*3] |-> discharge_on == ~rail_enable_in;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge wrong");
   property p_select; $stable(rail3_voltage_select) [*4] |->
      rail3_target_high == rail3_voltage_select; endproperty
   a_select: assert property (p_select) else $error("rail 3 target wrong");
   property p_disable; $fell(rail_enable_in[1]) |->
      ##[2:4] (!converter_run[1] && !rail_good_oe[1]); endproperty
   a_disable: assert property (p_disable) else $error("rail stayed on");
   property p_hot_start; converter_run[0] && $rose(rail_enable_in[1]) |->
      ##[1:4] converter_run[1]; endproperty
   a_hot_start: assert property (p_hot_start) else $error("late start");
   property p_wake; $rose(reference_on) |-> ((converter_run == 4'h0) throughout
      ##WK 1'b1) ##[0:2] (converter_run != 4'h0); endproperty
   a_wake: assert property (p_wake) else $error("wake delay wrong");
   property p_heat; $rose(overheat_trip) && converter_run != 4'h0 |-> ##4
      (rail_good_oe == 4'h0 && converter_run != 4'h0) ##[TR_LO:TR_HI] (converter_run == 4'h0);
   endproperty
   a_heat: assert property (p_heat) else $error("overheat timing wrong");
   property p_hold; $rose(rail_good_oe[0]) |-> low_q >= HL; endproperty
   a_hold: assert property (p_hold) else $error("good released early");
endmodule : rail_seq_monitor
bind quad_rail_sequencer_supervisor rail_seq_monitor #(.WAKE_CYCLES(WAKE_CYCLES),
   .HOLD_CYCLES(HOLD_CYCLES), .TRIP_CYCLES(TRIP_CYCLES)) mon (.clock, .resetn,
   .rail_enable_in, .rail3_voltage_select, .overheat_trip, .rail_good_out, .rail_good_oe,
   .converter_run, .discharge_on, .reference_on, .rail3_target_high);
`default_nettype wire

// ==== verification/rail_host_model.sv ====
// host side: drives enables, models rail outputs and the pulled-up good pins
// assumes the bench hands it the wanted enables and any sag on the rails
`timescale 1ns/1ps
`default_nettype none
module rail_host_model (
   input wire logic clock,
   input wire logic [3:0] want,
   input wire logic [3:0] sag,
   input wire logic [3:0] rail_good_oe,
   input wire logic [3:0] rail_good_out,
   input wire logic [3:0] converter_run,
   output logic [3:0] rail_enable_in,
   output logic [3:0] rail_feedback_node,
   output logic [3:0] good_pin
);
   logic [3:0] settled_q; // rail output lags its converter by a cycle
   initial
   begin
      rail_feedback_node = 4'h0;
      settled_q = 4'h0;
   end
   // change only at the falling edge, away from the sampling edge
   always @(negedge clock)
   begin
      settled_q <= converter_run;
      rail_feedback_node <= settled_q & ~sag; // sag forces a rail out of regulation
   end
   // enables follow the bench directly, so no negedge race decides the cycle
   assign rail_enable_in = want; // bench power-down lands after the trip delay has expired
   // a released pin floats up to the shared pullup
   assign good_pin = rail_good_oe | rail_good_out;
endmodule : rail_host_model
`default_nettype wire

// ==== verification/quad_rail_sequencer_supervisor_test.sv ====
// self-checking bench for the four-rail sequencer with short timers
// assumes the host model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module quad_rail_sequencer_supervisor_test
   import rail_seq_pkg::*;
;
   localparam int WAKE = 20, GAP = 30, HOLD = 200, TRIP = 50, SAFE = 300;
   logic clock, resetn, select, heat, low, high, ref_on, tgt;
   logic [3:0] want, sag, en, fb, gout, oe, run, dis, pin;
   int fail_count = 0, total_checks = 0, took;
   quad_rail_sequencer_supervisor #(.WAKE_CYCLES(WAKE), .GAP_CYCLES(GAP),
      .HOLD_CYCLES(HOLD), .TRIP_CYCLES(TRIP), .SAFETY_CYCLES(SAFE)) dut (.clock(clock),
      .resetn(resetn), .rail_enable_in(en), .rail3_voltage_select(select),
      .rail_feedback_node(fb), .overheat_trip(heat), .input_low_lockout(low),
      .input_high_trip(high), .rail_good_out(gout), .rail_good_oe(oe), .converter_run(run),
      .discharge_on(dis), .reference_on(ref_on), .rail3_target_high(tgt));
   rail_host_model host (.clock(clock), .want(want), .sag(sag), .rail_good_oe(oe),
      .rail_good_out(gout), .converter_run(run), .rail_enable_in(en),
      .rail_feedback_node(fb), .good_pin(pin));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   // bounded wait for one converter to start
   task automatic wait_run(input int i, output int n);
      n = 0;
      while (run[i] !== 1'b1 && n < 2000)
      begin
         @(negedge clock);
         n++;
      end
   endtask : wait_run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // watchdog well beyond the roughly 1600 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clock);
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      {resetn, select, heat, low, high, want, sag} = '0;
      tick(5);
      resetn = 1'b1;
      check("discharge", dis, 4'hF);
      check("reference", {3'h0, ref_on}, 4'h0);
      want = 4'h1;
      tick(4);
      check("early run", run, 4'h0);
      wait_run(0, took);
      check("wake", {3'h0, took inside {[WAKE-6:WAKE+1]}}, 4'h1);
      tick(6);
      check("good up", oe, 4'h1);
      want = 4'h3;
      tick(5);
      check("hot start", run, 4'h3);
      for (int v = 0; v < 2; v++)
      begin
         select = v[0];
         tick(5);
         check("target", {3'h0, tgt}, {3'h0, v ? RAIL3_HIGH_SETTING : RAIL3_LOW_SETTING});
      end
      sag = 4'h2;
      tick(5);
      check("sag good", pin, 4'h1);
      sag = 4'h0;
      tick(20);
      check("held", oe, 4'h1);
      tick(HOLD);
      check("recover", oe, 4'h3);
      want = 4'h1;
      tick(5);
      check("off run", run, 4'h1);
      check("off pull", dis, 4'hE);
      want = 4'hF;
      tick(10);
      heat = 1'b1;
      tick(5);
      check("heat good", oe, 4'h0);
      check("heat run", run, 4'hF);
      tick(TRIP);
      check("heat off", run, 4'h0);
      heat = 1'b0;
      tick(SAFE - 10);
      check("safety", run, 4'h0);
      wait_run(0, took);
      for (int i = 1; i < 4; i++)
      begin
         wait_run(i, took);
         check("gap", {3'h0, took inside {[GAP-2:GAP+2]}}, 4'h1);
         check("order", run, 4'((1 << (i + 1)) - 1));
      end
      tick(HOLD + 20);
      low = 1'b1;
      tick(4);
      check("low run", run | oe, 4'h0);
      low = 1'b0;
      wait_run(3, took);
      check("low restart", run, 4'hF);
      check("low hold", oe, 4'h0);
      tick(HOLD);
      check("low release", oe, 4'hF);
      high = 1'b1;
      tick(15);
      check("high good", oe, 4'h0);
      high = 1'b0;
      tick(TRIP);
      check("short high", run, 4'hF);
      check("short hold", oe, 4'h0);
      tick(HOLD);
      high = 1'b1;
      tick(TRIP + 10);
      check("long high", run, 4'h0);
      {high, want} = '0;
      tick(20);
      check("shutdown", {3'h0, ref_on}, 4'h0);
      report_and_stop();
   end
endmodule : quad_rail_sequencer_supervisor_test
`default_nettype wire
